// ### hdl/psd_pkg.sv
// Package for the PHY strap defaults loader: register map, field positions, strap defaults.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
package psd_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_STRAP_STATE = 8'h00;
  localparam logic [7:0] OFF_HARDWARE_CONFIG_REGISTER = 8'h04;
  localparam logic [7:0] OFF_BASIC_CTL = 8'h08;
  localparam logic [7:0] OFF_ADVERT = 8'h0C;
  localparam logic [7:0] OFF_MODES = 8'h10;
  localparam logic [7:0] OFF_SPECIAL_CTL = 8'h14;
  localparam logic [7:0] OFF_CONTROL = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int HW_AUTOX_BIT = 0;
  localparam int BC_DUPLEX_BIT = 8;
  localparam int BC_AN_BIT = 12;
  localparam int BC_SPEED_BIT = 13;
  localparam int ADV_10HD_BIT = 5;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_SYM_BIT = 10;
  localparam int ADV_ASYM_BIT = 11;
  localparam int MODE_LSB = 5;
  localparam int SC_XCTRL_BIT = 15;
  localparam int SC_XSEL_BIT = 13;
  localparam int SC_XEN_BIT = 14;
  localparam int CTL_RELOAD_BIT = 0;
  localparam int CTL_DIGRST_BIT = 1;

  // ==========================================================================
  // Strap defaults, fiber and selector values
  localparam logic [7:0] STRAP_RESET = 8'h7A;
  localparam logic [2:0] MODE_ALLCAP = 3'h7;
  localparam logic [2:0] MODE_FX = 3'h3;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic manualFlowCtl;
    logic fullDuplexFlowCtl;
    logic duplex;
    logic speed;
    logic autoneg;
    logic manualCrossover;
    logic autoCrossover;
    logic spare;
  } psd_straps_t;

  typedef struct packed {
    logic autoneg;
    logic speedLow;
    logic duplex;
    logic adv10Fd;
    logic adv10Hd;
    logic advSym;
    logic advAsym;
    logic [2:0] mode;
  } psd_defaults_t;

endpackage

// ### hdl/psd_strap_loader.sv
// PHY strap defaults loader: latches soft straps, takes EEPROM overrides, builds PHY reset defaults.
// Assumes strap pins are asynchronous and the EEPROM loader pulses eepromLoad on clk_sys.
// How it works
// - Auto-crossover strap is hardware config default
// - Strap mode uses auto and manual crossover
// - Manual strap forces MDI at 0, MDIX 1
// - Autoneg strap sets negotiation enable default
// - Autoneg strap shapes speed, duplex, advert, mode
// - Speed strap shapes speed, 10M advert, mode
// - Duplex strap shapes duplex, 10FD advert, mode
// - Full-duplex flow strap shapes asymmetric pause
// - Manual flow strap shapes both pause bits
// - Fiber mode ignores all but duplex strap
// - Pins captured at reset release; EEPROM overrides
// - Digital reset restores latched pin values; reload only reapplies defaults
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module psd_strap_loader (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic autoCrossoverPin,
  input wire logic manualCrossoverPin,
  input wire logic autonegPin,
  input wire logic speedPin,
  input wire logic duplexPin,
  input wire logic fullDuplexFlowCtlPin,
  input wire logic manualFlowCtlPin,
  input wire logic fiberModePin,
  input wire logic eepromLoad,
  input wire logic eepromValid,
  input wire psd_pkg::psd_straps_t eepromStraps,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic crossoverAuto,
  output logic crossoverMdix,
  output logic [15:0] phyBasicCtl,
  output logic [15:0] phyAdvert,
  output logic [2:0] phyMode
);

  // ==========================================================================
  // Pin synchronisers
  psd_pkg::psd_straps_t pinMeta_ff;
  psd_pkg::psd_straps_t pinSync_ff;
  logic fiberMeta_ff;
  logic fiberSync_ff;
  logic resetSeen_ff;
  // Captured and active straps
  psd_pkg::psd_straps_t pinLatched_ff;
  psd_pkg::psd_straps_t active_ff;
  logic fiber_ff;
  logic reapply_ff;
  logic nxt_reapply;
  // PHY register images
  logic [15:0] basic_ff;
  logic [15:0] advert_ff;
  logic [15:0] special_ff;
  logic [2:0] mode_ff;
  psd_pkg::psd_defaults_t dflt;
  logic wrHit;
  logic [1:0] ctlPulse;

  // Field by field, so a reordered struct cannot swap two straps unnoticed
  always_ff @(posedge clk_sys) begin
    pinMeta_ff.manualFlowCtl <= manualFlowCtlPin;
    pinMeta_ff.fullDuplexFlowCtl <= fullDuplexFlowCtlPin;
    pinMeta_ff.duplex <= duplexPin;
    pinMeta_ff.speed <= speedPin;
    pinMeta_ff.autoneg <= autonegPin;
    pinMeta_ff.manualCrossover <= manualCrossoverPin;
    pinMeta_ff.autoCrossover <= autoCrossoverPin;
    pinMeta_ff.spare <= 1'b0;
    pinSync_ff <= pinMeta_ff;
  end

  always_ff @(posedge clk_sys) begin
    fiberMeta_ff <= fiberModePin;
    fiberSync_ff <= fiberMeta_ff;
  end

  // ==========================================================================
  // Helpers
  function automatic psd_pkg::psd_straps_t strapDefault();
    return psd_pkg::psd_straps_t'(psd_pkg::STRAP_RESET);
  endfunction

  function automatic logic regWrite(input logic hit, input logic [7:0] addr, input logic [7:0] want);
    return hit && addr == want;
  endfunction

  // Byte lanes of a 16-bit register; lanes not enabled keep their old value
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [15:0] wdata, input logic [1:0] be);
    logic [15:0] w;
    w = old;
    if (be[0]) begin
      w[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      w[15:8] = wdata[15:8];
    end
    return w;
  endfunction

  // ==========================================================================
  // Strap capture; pins are sampled once, on the first cycle after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resetSeen_ff <= 1'b0;
    end else begin
      resetSeen_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pinLatched_ff <= strapDefault();
      fiber_ff <= 1'b0;
    // Fiber select comes from its pin only; the EEPROM image carries no fiber bit
    end else if (!resetSeen_ff) begin
      pinLatched_ff <= pinSync_ff;
      fiber_ff <= fiberSync_ff;
    end
  end

  // Software writes to the control register give one-cycle reload / digital reset pulses
  assign wrHit = avs_write && !avs_waitrequest;

  always_comb begin
    ctlPulse = 2'h0;
    if (regWrite(wrHit, avs_address, psd_pkg::OFF_CONTROL) && avs_byteenable[0]) begin
      ctlPulse = {avs_writedata[psd_pkg::CTL_DIGRST_BIT], avs_writedata[psd_pkg::CTL_RELOAD_BIT]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_ff <= strapDefault();
    end else if (!resetSeen_ff) begin
      active_ff <= pinSync_ff;
    end else if (eepromLoad && eepromValid) begin
      active_ff <= eepromStraps;
    end else if ((eepromLoad && !eepromValid) || ctlPulse[1]) begin
      active_ff <= pinLatched_ff;
    end
  end

  // Defaults are reapplied one cycle after the straps settle
  // A PHY register write in a reapply cycle is lost; the strap default wins
  always_comb begin
    nxt_reapply = !resetSeen_ff || eepromLoad || ctlPulse[1] || ctlPulse[0];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reapply_ff <= 1'b1;
    end else begin
      reapply_ff <= nxt_reapply;
    end
  end

  // ==========================================================================
  // Default derivation
  function automatic psd_pkg::psd_defaults_t derive(input psd_pkg::psd_straps_t s, input logic fx);
    psd_pkg::psd_defaults_t d;
    d.autoneg = s.autoneg;
    d.speedLow = s.speed;
    d.duplex = s.duplex;
    d.adv10Hd = s.autoneg | ~s.speed;
    d.adv10Fd = (s.autoneg | ~s.speed) & s.duplex;
    d.advSym = s.manualFlowCtl;
    d.advAsym = s.manualFlowCtl | s.fullDuplexFlowCtl;
    d.mode = s.autoneg ? psd_pkg::MODE_ALLCAP : {1'b0, s.speed, s.duplex};
    if (s.autoneg) begin
      d.speedLow = 1'b1;
      d.duplex = 1'b1;
    end
    if (fx) begin
      d = deriveFiber(s);
    end
    return d;
  endfunction

  // Fiber: only the duplex strap still counts, speed fixed at 100
  function automatic psd_pkg::psd_defaults_t deriveFiber(input psd_pkg::psd_straps_t s);
    psd_pkg::psd_defaults_t d;
    d.autoneg = 1'b0;
    d.speedLow = 1'b1;
    d.duplex = s.duplex;
    d.adv10Hd = 1'b0;
    d.adv10Fd = 1'b0;
    d.advSym = 1'b0;
    d.advAsym = 1'b0;
    d.mode = {psd_pkg::MODE_FX[2:1], s.duplex};
    return d;
  endfunction

  function automatic logic [15:0] packBasic(input psd_pkg::psd_defaults_t d);
    logic [15:0] w;
    w = 16'h0000;
    w[psd_pkg::BC_AN_BIT] = d.autoneg;
    w[psd_pkg::BC_SPEED_BIT] = d.speedLow;
    w[psd_pkg::BC_DUPLEX_BIT] = d.duplex;
    return w;
  endfunction

  function automatic logic [15:0] packAdvert(input psd_pkg::psd_defaults_t d);
    logic [15:0] w;
    w = 16'h0000;
    w[psd_pkg::ADV_10HD_BIT] = d.adv10Hd;
    w[psd_pkg::ADV_10FD_BIT] = d.adv10Fd;
    w[psd_pkg::ADV_SYM_BIT] = d.advSym;
    w[psd_pkg::ADV_ASYM_BIT] = d.advAsym;
    return w;
  endfunction

  // Fiber has no crossover, so straps and override bits are ignored there
  function automatic logic [1:0] xoverSelect(input logic fx, input logic [15:0] special, input psd_pkg::psd_straps_t st);
    logic [1:0] x;
    if (fx) begin
      x = 2'b00;
    end else if (special[psd_pkg::SC_XCTRL_BIT]) begin
      x = {st.autoCrossover, !st.autoCrossover && st.manualCrossover};
    end else begin
      x = {special[psd_pkg::SC_XEN_BIT], special[psd_pkg::SC_XSEL_BIT]};
    end
    return x;
  endfunction

  assign dflt = derive(active_ff, fiber_ff);

  // ==========================================================================
  // PHY registers: reset defaults from straps, then software owned
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      basic_ff <= 16'h0000;
    end else if (reapply_ff) begin
      basic_ff <= packBasic(dflt);
    end else if (regWrite(wrHit, avs_address, psd_pkg::OFF_BASIC_CTL)) begin
      basic_ff <= laneMerge(basic_ff, avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      advert_ff <= 16'h0000;
    end else if (reapply_ff) begin
      advert_ff <= packAdvert(dflt);
    end else if (regWrite(wrHit, avs_address, psd_pkg::OFF_ADVERT)) begin
      advert_ff <= laneMerge(advert_ff, avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_ff <= psd_pkg::MODE_ALLCAP;
    end else if (reapply_ff) begin
      mode_ff <= dflt.mode;
    end else if (regWrite(wrHit, avs_address, psd_pkg::OFF_MODES) && avs_byteenable[0]) begin
      mode_ff <= avs_writedata[psd_pkg::MODE_LSB +: 3];
    end
  end

  // Crossover control: bit 15 set selects strap-based crossover
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      special_ff <= 16'h0000;
    end else if (reapply_ff) begin
      special_ff <= 16'h0000;
      special_ff[psd_pkg::SC_XCTRL_BIT] <= 1'b1;
    end else if (regWrite(wrHit, avs_address, psd_pkg::OFF_SPECIAL_CTL)) begin
      special_ff <= laneMerge(special_ff, avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  // ==========================================================================
  // Crossover decision
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crossoverAuto <= 1'b1;
      crossoverMdix <= 1'b0;
    end else begin
      {crossoverAuto, crossoverMdix} <= xoverSelect(fiber_ff, special_ff, active_ff);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phyBasicCtl <= 16'h0000;
      phyAdvert <= 16'h0000;
      phyMode <= psd_pkg::MODE_ALLCAP;
    end else begin
      phyBasicCtl <= basic_ff;
      phyAdvert <= advert_ff;
      phyMode <= mode_ff;
    end
  end

  // ==========================================================================
  // Avalon-MM slave. Waitrequest comes from a flop, so it idles high and every
  // read or write sees one wait state; the request is taken when it drops
  function automatic logic [31:0] readMux(
    input logic [7:0] addr,
    input logic fx,
    input psd_pkg::psd_straps_t st,
    input logic [15:0] basic,
    input logic [15:0] advert,
    input logic [2:0] mode,
    input logic [15:0] special
  );
    logic [31:0] r;
    case (addr)
      psd_pkg::OFF_STRAP_STATE: r = {23'h000000, fx, st};
      psd_pkg::OFF_HARDWARE_CONFIG_REGISTER: r = {31'h00000000, st.autoCrossover};
      psd_pkg::OFF_BASIC_CTL: r = {16'h0000, basic};
      psd_pkg::OFF_ADVERT: r = {16'h0000, advert};
      psd_pkg::OFF_MODES: r = {24'h000000, mode, 5'h00};
      psd_pkg::OFF_SPECIAL_CTL: r = {16'h0000, special};
      default: r = psd_pkg::RD_UNMAPPED;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Read data are fetched when the request is first seen and stand until the next read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= psd_pkg::RD_UNMAPPED;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= readMux(avs_address, fiber_ff, active_ff, basic_ff, advert_ff, mode_ff, special_ff);
    end
  end

endmodule

// ### tb/psd_strap_src.sv
// Model of the strap pins and the EEPROM loader's result lines.
// Assumes the bench calls its tasks from the clk_sys domain.
`timescale 1ns/1ns
module psd_strap_src (
  input wire logic clk_sys,
  output psd_pkg::psd_straps_t pinStraps,
  output logic fiberPin,
  output logic eepromLoad,
  output logic eepromValid,
  output psd_pkg::psd_straps_t eepromStraps
);
  initial begin
    pinStraps = 8'h7A;
    fiberPin = 1'b0;
    eepromLoad = 1'b0;
    eepromValid = 1'b0;
    eepromStraps = 8'h00;
  end
  task automatic pins(input psd_pkg::psd_straps_t s, input logic f);
    @(posedge clk_sys);
    pinStraps <= s;
    fiberPin <= f;
  endtask
  // Image lines flip once the pulse is over, so a stale image cannot pass
  task automatic load(input logic v, input psd_pkg::psd_straps_t s);
    @(posedge clk_sys);
    eepromLoad <= 1'b1;
    eepromValid <= v;
    eepromStraps <= s;
    @(posedge clk_sys);
    eepromLoad <= 1'b0;
    eepromStraps <= ~s;
  endtask
endmodule

// ### tb/psd_strap_loader_props.sv
// Checker for the strap defaults loader, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module psd_strap_loader_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic crossoverAuto,
  input wire logic crossoverMdix,
  input wire logic [15:0] phyBasicCtl,
  input wire logic [15:0] phyAdvert,
  input wire logic [2:0] phyMode
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_reset_vals:
    assert property (disable iff (1'b0) !rst_n |=> phyMode == 3'h7 && crossoverAuto && !crossoverMdix
      && phyBasicCtl == 16'h0000 && phyAdvert == 16'h0000) else $error("Reset values wrong");
  chk_read_wait:
    assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("Read wait wrong");
  chk_write_wait:
    assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("Write wait wrong");
  chk_idle_wait:
    assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("Idle wait low");
  chk_rd_hold:
    assert property (!avs_read |=> $stable(avs_readdata)) else $error("Read data moved");
  chk_unmapped_zero:
    assert property (avs_read && !avs_waitrequest && avs_address > 8'h18 |-> avs_readdata == 32'h0000_0000)
      else $error("Unmapped read not zero");
  chk_an_speed:
    assert property (phyBasicCtl[12] |-> phyBasicCtl[13] && phyBasicCtl[8]) else $error("Autoneg speed wrong");
  chk_an_advert:
    assert property (phyBasicCtl[12] |-> phyAdvert[5] && phyMode == 3'h7) else $error("Autoneg advert wrong");
  chk_pause_pair:
    assert property (phyAdvert[10] |-> phyAdvert[11]) else $error("Pause pair wrong");
  chk_mdix_forced:
    assert property (crossoverMdix |-> !crossoverAuto) else $error("Forced crossover wrong");
  cover property (phyBasicCtl[12]);
  cover property (crossoverMdix);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind psd_strap_loader psd_strap_loader_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .crossoverAuto(crossoverAuto), .crossoverMdix(crossoverMdix), .phyBasicCtl(phyBasicCtl),
  .phyAdvert(phyAdvert), .phyMode(phyMode));

// ### tb/tb_phy_strap_defaults.sv
// Bench for the strap defaults loader: pin resets, EEPROM loads, register access.
// Assumes the strap source model and the checker are compiled first.
`timescale 1ns/1ns
module tb_phy_strap_defaults;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, crossoverAuto, crossoverMdix;
  logic fiberPin, eepromLoad, eepromValid;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [15:0] phyBasicCtl, phyAdvert;
  logic [2:0] phyMode;
  logic [8:0] tbl [5] = '{9'h1EA, 9'h108, 9'h07A, 9'h0A4, 9'h010};
  psd_pkg::psd_straps_t pinStraps, eepromStraps;
  int errors, n_tests;
  psd_strap_src u_src (.clk_sys(clk_sys), .pinStraps(pinStraps), .fiberPin(fiberPin), .eepromLoad(eepromLoad),
    .eepromValid(eepromValid), .eepromStraps(eepromStraps));
  psd_strap_loader u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .autoCrossoverPin(pinStraps.autoCrossover),
    .manualCrossoverPin(pinStraps.manualCrossover), .autonegPin(pinStraps.autoneg), .speedPin(pinStraps.speed),
    .duplexPin(pinStraps.duplex), .fullDuplexFlowCtlPin(pinStraps.fullDuplexFlowCtl),
    .manualFlowCtlPin(pinStraps.manualFlowCtl), .fiberModePin(fiberPin), .eepromLoad(eepromLoad),
    .eepromValid(eepromValid), .eepromStraps(eepromStraps), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crossoverAuto(crossoverAuto),
    .crossoverMdix(crossoverMdix), .phyBasicCtl(phyBasicCtl), .phyAdvert(phyAdvert), .phyMode(phyMode));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    avs_read <= 1'b1;
    avs_address <= a;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    rdat = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    avs_write <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic prst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  // Advert 10M bits are only compared where autoneg or fiber mode fixes them
  task automatic chk_def(input psd_pkg::psd_straps_t s, input logic f);
    logic an, dx;
    logic [3:0] m;
    an = s.autoneg & ~f;
    dx = an | s.duplex;
    m = (an | f) ? 4'hF : 4'hC;
    chk("basic", {an, f | an | s.speed, dx}, {phyBasicCtl[12], phyBasicCtl[13], phyBasicCtl[8]});
    chk("advert", f ? 4'h0 : {s.manualFlowCtl | s.fullDuplexFlowCtl, s.manualFlowCtl, s.duplex, 1'b1} & m,
      {phyAdvert[11:10], phyAdvert[6:5]} & m);
    chk("mode", f ? {2'b01, s.duplex} : (an ? 3'h7 : {1'b0, s.speed, s.duplex}), phyMode);
    if (f) chk("xover", 2'b00, {crossoverAuto, crossoverMdix});
  endtask
  task automatic close_out();
    $display("Comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    for (int i = 0; i < 5; i++) begin
      u_src.pins(tbl[i][7:0], tbl[i][8]);
      prst();
      chk_def(tbl[i][7:0], tbl[i][8]);
      rd(psd_pkg::OFF_STRAP_STATE);
      chk("state", {23'h0, tbl[i]}, rdat);
      rd(psd_pkg::OFF_HARDWARE_CONFIG_REGISTER);
      chk("hwcfg", tbl[i][1], rdat[0]);
    end
    for (int i = 0; i < 3; i++) begin
      u_src.load(1'b1, 8'h02 << i);
      repeat (4) @(posedge clk_sys);
      chk_def(8'h02 << i, 1'b0);
      wr(psd_pkg::OFF_SPECIAL_CTL, 32'h0000_8000);
      chk("xover", {i == 0, i == 1}, {crossoverAuto, crossoverMdix});
    end
    u_src.pins(8'hFF, 1'b0);
    u_src.load(1'b0, 8'hFF);
    repeat (4) @(posedge clk_sys);
    rd(psd_pkg::OFF_STRAP_STATE);
    chk("revert", 32'h0000_0010, rdat);
    u_src.load(1'b1, 8'h08);
    wr(psd_pkg::OFF_STRAP_STATE, 32'h0000_0000);
    wr(psd_pkg::OFF_CONTROL, 32'h0000_0002);
    rd(psd_pkg::OFF_STRAP_STATE);
    chk("digrst", 32'h0000_0010, rdat);
    chk_def(8'h10, 1'b0);
    wr(psd_pkg::OFF_BASIC_CTL, 32'h0000_0100);
    rd(psd_pkg::OFF_BASIC_CTL);
    chk("swbasic", 16'h0100, rdat[15:0]);
    wr(psd_pkg::OFF_CONTROL, 32'h0000_0001);
    chk_def(8'h10, 1'b0);
    rd(8'hFC);
    chk("unmapped", 32'h0000_0000, rdat);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    close_out();
  end
endmodule
